// [core/arrf_pkg.sv]
// package: constants and types for the converter result and range-flag output stage
`default_nettype none
package arrf_pkg;
  localparam int RES_W = 12;                 // result width
  localparam int FIFO_DEPTH = 4;             // quantiser sample buffer depth
  localparam int CONV_CYCLES = 40;           // conversion time in sys_clk cycles
  localparam int STROBE_HIGH_CYCLES = 20;    // result_valid_strobe high time
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_FULL = 12'hFFF;
  localparam logic [12:0] FLAG_THRESH_HS = 13'h0001; // flag when sample beyond range by more than this many half-steps
  typedef enum logic [1:0] {
    ARRF_RANGE_U2P5,
    ARRF_RANGE_U5,
    ARRF_RANGE_B2P5,
    ARRF_RANGE_B5
  } arrf_range_t;
  typedef enum {ARRF_IDLE, ARRF_CONVERT, ARRF_PRESENT} arrf_state_t;
endpackage
`default_nettype wire

// [core/arrf_fifo.sv]
// fifo: small parameterised buffer of quantiser samples
`timescale 1ns/1ps
`default_nettype none
module arrf_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk_i, // clock
  input  wire logic             resetn_i,  // async reset, active low
  input  wire logic             in_valid_i, // write request
  output logic                  in_ready_o, // not full
  input  wire logic [WIDTH-1:0] in_data_i, // write data
  output logic                  out_valid_o, // not empty
  input  wire logic             out_ready_i, // read accept
  output logic [WIDTH-1:0]      out_data_o // head data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      count_reg;
  wire              do_wr;
  wire              do_rd;

  // full and empty come straight from the occupancy count
  assign in_ready_o  = (count_reg < (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem[rptr_reg];
  assign do_wr       = in_valid_i && in_ready_o;
  assign do_rd       = out_valid_o && out_ready_i;

  // storage has no reset, only pointers and count do
  always_ff @(posedge sys_clk_i) begin
    if (do_wr) begin
      mem[wptr_reg] <= in_data_i;
    end
  end

  // pointer and count update
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (do_rd) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule // arrf_fifo
`default_nettype wire

// [core/arrf_core.sv]
// core: converter output stage with result strobe, range flag and coding
// Functional notes
// [RULE1] new data valid at strobe rising edge
// [RULE2] inverted strobe captures previous result
// [RULE3] input outside selected range is out-of-range
// [RULE4] flag low when input within range
// [RULE5] flag rises half step beyond full scale
// [RULE6] flag holds until in-range conversion completes
// [RULE7] host combines flag and top bit
// [RULE8] true and complemented top bit outputs
// [RULE9] saturate result high above, low below
// [RULE10] acquire on strobe fall, hold until command
// [RULE11] host registers flag with result together
`timescale 1ns/1ps
`default_nettype none
module arrf_core #(
  parameter int RES_W       = arrf_pkg::RES_W,
  parameter int FIFO_DEPTH  = arrf_pkg::FIFO_DEPTH,
  parameter int CONV_CYCLES = arrf_pkg::CONV_CYCLES,
  parameter int STRB_CYCLES = arrf_pkg::STROBE_HIGH_CYCLES
) (
  input  wire logic                sys_clk_i,            // 50 MHz clock
  input  wire logic                resetn_i,             // async reset, active low
  input  wire logic                conversion_command_i, // start pulse, pin
  input  wire logic [1:0]          range_sel_i,          // selected input range, pin
  input  wire logic signed [14:0]  sample_i,             // quantiser in half-steps, valid in acquire
  input  wire logic                sample_valid_i,       // quantiser data ready
  output logic                     sample_ready_o,       // accepting quantiser data
  output logic                     acquire_o,            // sampler in acquire mode
  output logic [RES_W-1:0]         result_o,             // conversion result, true top bit
  output logic                     top_bit_n_o,          // complemented top bit
  output logic                     range_exceeded_flag_o, // out-of-range flag
  output logic                     result_valid_strobe_o // data-available strobe
);
  // sample_i: signed half-step count relative to range bottom; in-range spans 0..2*4095+1

  localparam int CW = $clog2(CONV_CYCLES + STRB_CYCLES + 1);
  // one sign bit and one headroom bit above the span, so overrange never wraps negative
  localparam int SPAN_HS = (2 ** (RES_W + 1)) - 1; // top of full-scale code in half-steps

  // pin synchronisers
  logic [1:0] cmd_sync_reg;
  logic       cmd_prev_reg;
  logic [1:0] rsel_s1_reg;
  logic [1:0] rsel_s2_reg;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_sync_reg <= 2'h0;
      cmd_prev_reg <= 1'b0;
      rsel_s1_reg  <= 2'h0;
      rsel_s2_reg  <= 2'h0;
    end else begin
      cmd_sync_reg <= {cmd_sync_reg[0], conversion_command_i};
      cmd_prev_reg <= cmd_sync_reg[1];
      rsel_s1_reg  <= range_sel_i;
      rsel_s2_reg  <= rsel_s1_reg;
    end
  end

  wire cmd_rise = cmd_sync_reg[1] && !cmd_prev_reg;

  // range evaluation: all four ranges share the same code span, so one compare serves;
  // worked in int so the threshold sum cannot overflow the sample width
  function automatic logic [1:0] arrf_classify(input logic signed [14:0] hs);
    int v;
    int lim;
    v   = int'(hs);
    lim = int'(arrf_pkg::FLAG_THRESH_HS);
    // bit1 = above, bit0 = below
    arrf_classify = {v > (SPAN_HS + lim),   // RULE5
                     v < (0 - lim)};        // RULE5
  endfunction

  // code selection: clamp at both ends of the span, else drop the half step;
  // clamping also covers samples just past the span but inside the flag threshold,
  // which would otherwise wrap to the opposite end of the code range
  function automatic logic [RES_W-1:0] arrf_code(input logic signed [14:0] hs);
    int v;
    v = int'(hs);
    if (v > SPAN_HS) begin
      arrf_code = arrf_pkg::CODE_FULL;      // RULE9
    end else if (v < 0) begin
      arrf_code = arrf_pkg::CODE_ZERO;      // RULE9
    end else begin
      arrf_code = hs[RES_W:1];
    end
  endfunction

  // sample path: quantiser words land in the fifo; when full, an offered word stalls one cycle while the oldest entry is dropped
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic [14:0] fifo_out_data;
  logic        fifo_out_valid;
  logic        fifo_out_ready;

  arrf_fifo #(
    .WIDTH(15),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .in_valid_i (fifo_in_valid),
    .in_ready_o (fifo_in_ready),
    .in_data_i  (sample_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o (fifo_out_data)
  );

  arrf_pkg::arrf_state_t state_reg;
  arrf_pkg::arrf_state_t state_next;
  logic [CW-1:0]         cnt_reg;
  logic [CW-1:0]         cnt_next;
  logic signed [14:0]    held_reg;
  logic [RES_W-1:0]      result_reg;
  logic                  flag_reg;
  logic                  strobe_reg;
  arrf_pkg::arrf_range_t range_reg;

  // quantiser words accepted only while acquiring
  assign acquire_o      = (state_reg != arrf_pkg::ARRF_PRESENT) || !strobe_reg; // RULE10
  assign fifo_in_valid  = sample_valid_i && acquire_o;
  assign sample_ready_o = fifo_in_ready && acquire_o;

  // head of fifo is the held sample; it is popped when a command begins conversion
  wire        start_conv = cmd_rise && (state_reg == arrf_pkg::ARRF_IDLE) && fifo_out_valid;
  assign fifo_out_ready = start_conv || (fifo_out_valid && fifo_in_valid && !fifo_in_ready);

  // classification and code of the held sample
  wire [1:0]        cls    = arrf_classify(held_reg);
  wire              oor    = |cls;                                  // RULE3
  wire [RES_W-1:0]  code   = arrf_code(held_reg);                   // RULE9

  // sequencer: idle until command, convert, then raise strobe with data
  // timing: start taken, result and flag load when the count reaches one,
  // strobe rises at the next edge and stands for STRB_CYCLES cycles;
  // limitation: CONV_CYCLES below 2 never reaches the load point, so keep it at 2 or more
  // commands arriving while converting or presenting are dropped, not queued
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      arrf_pkg::ARRF_IDLE: begin
        if (start_conv) begin
          state_next = arrf_pkg::ARRF_CONVERT;
          cnt_next   = CW'(CONV_CYCLES - 1);
        end
      end
      arrf_pkg::ARRF_CONVERT: begin
        if (cnt_reg == '0) begin
          state_next = arrf_pkg::ARRF_PRESENT;
          cnt_next   = CW'(STRB_CYCLES - 1);
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      arrf_pkg::ARRF_PRESENT: begin
        if (cnt_reg == '0) begin
          state_next = arrf_pkg::ARRF_IDLE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: state_next = arrf_pkg::ARRF_IDLE;
    endcase
  end

  wire present_enter = (state_reg == arrf_pkg::ARRF_CONVERT) && (cnt_reg == '0);

  // state and outputs; data and flag update one cycle before the strobe rises
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg  <= arrf_pkg::ARRF_IDLE;
      cnt_reg    <= '0;
      held_reg   <= 15'h0000;
      result_reg <= arrf_pkg::CODE_ZERO;
      flag_reg   <= 1'b0;
      strobe_reg <= 1'b0;
      range_reg  <= arrf_pkg::ARRF_RANGE_U2P5;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (start_conv) begin
        held_reg  <= fifo_out_data;                       // RULE10
        range_reg <= arrf_pkg::arrf_range_t'(rsel_s2_reg);
      end
      if ((state_reg == arrf_pkg::ARRF_CONVERT) && (cnt_reg == CW'(1))) begin
        result_reg <= code;                               // RULE1
        flag_reg   <= oor;                                // RULE4 RULE6
      end
      strobe_reg <= present_enter || ((state_reg == arrf_pkg::ARRF_PRESENT) && (cnt_reg != '0));
    end
  end

  // flag only changes at a completed conversion, so it stays paired with its result
  assign result_o              = result_reg;              // RULE1
  assign top_bit_n_o           = ~result_reg[RES_W-1];    // RULE8
  assign range_exceeded_flag_o = flag_reg;                // RULE5
  assign result_valid_strobe_o = strobe_reg;              // RULE1
endmodule // arrf_core
`default_nettype wire

// [verification/arrf_checker.sv]
// checker: timing and coding properties of the output stage
`timescale 1ns/1ps
`default_nettype none
module arrf_checker #(
  parameter int RES_W       = 12,
  parameter int STRB_CYCLES = 20
) (
  input wire logic             sys_clk_i,             // clock
  input wire logic             resetn_i,              // reset, active low
  input wire logic             sample_ready_o,        // quantiser accept
  input wire logic             acquire_o,             // acquire mode
  input wire logic [RES_W-1:0] result_o,              // result
  input wire logic             top_bit_n_o,           // inverted top bit
  input wire logic             range_exceeded_flag_o, // range flag
  input wire logic             result_valid_strobe_o  // strobe
);
  wire       stb = result_valid_strobe_o;
  wire       flg = range_exceeded_flag_o;
  logic [7:0] hi_cnt_reg;
  // count high cycles here: a long repetition would unroll badly
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) hi_cnt_reg <= 8'h00;
    else hi_cnt_reg <= stb ? hi_cnt_reg + 8'h01 : 8'h00;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  a_strobe_width: assert property ($fell(stb) |-> hi_cnt_reg == STRB_CYCLES)
    else $error("strobe width wrong");
  a_data_settled: assert property ($rose(stb) |-> $stable(result_o) && $stable(flg))
    else $error("data not settled at strobe rise");
  a_update_strobe: assert property ($changed({flg, result_o}) |=> stb)
    else $error("new data without strobe");
  a_flag_hold: assert property (stb && $past(stb) |-> $stable(flg) && $stable(result_o))
    else $error("data moved while presented");
  a_top_inverse: assert property (top_bit_n_o == !result_o[RES_W-1])
    else $error("complement top bit wrong");
  a_sat_high: assert property (flg && result_o[RES_W-1] |-> &result_o)
    else $error("overrange not saturated");
  a_sat_low: assert property (flg && !result_o[RES_W-1] |-> ~|result_o)
    else $error("underrange not zero");
  a_acquire_mode: assert property (acquire_o == !stb)
    else $error("acquire mode wrong");
  a_sample_block: assert property (stb |-> !sample_ready_o)
    else $error("sample taken while held");
endmodule // arrf_checker
bind arrf_core arrf_checker #(.RES_W(RES_W), .STRB_CYCLES(STRB_CYCLES)) arrf_checker_i (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sample_ready_o(sample_ready_o),
  .acquire_o(acquire_o), .result_o(result_o), .top_bit_n_o(top_bit_n_o),
  .range_exceeded_flag_o(range_exceeded_flag_o),
  .result_valid_strobe_o(result_valid_strobe_o));
`default_nettype wire

// [verification/arrf_latch_model.sv]
// partner: host output latches and range decode
`timescale 1ns/1ps
`default_nettype none
module arrf_latch_model (
  input  wire logic        strobe_i,    // result valid strobe
  input  wire logic [11:0] result_i,    // converter result
  input  wire logic        flag_i,      // range flag
  output logic      [11:0] new_data_o,  // latched on strobe rise
  output logic             new_flag_o,  // flag latched with data
  output logic      [11:0] prev_data_o, // latched on inverted strobe
  output logic      [1:0]  class_o      // 0 in range, 1 under, 2 over
);
  // one edge for flag and data keeps them paired
  always_ff @(posedge strobe_i) begin
    new_data_o <= result_i;
    new_flag_o <= flag_i;
  end
  // inverted strobe latch samples at the falling edge
  always_ff @(negedge strobe_i) prev_data_o <= result_i;
  // host decode of flag with top bit
  assign class_o = !new_flag_o ? 2'h0 : (new_data_o[11] ? 2'h2 : 2'h1);
endmodule // arrf_latch_model
`default_nettype wire

// [verification/adc_result_range_flag_tb.sv]
// testbench: conversions, range flag, coding and buffering
`timescale 1ns/1ps
`default_nettype none
module adc_result_range_flag_tb;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, cmd = 1'b0, svalid = 1'b0;
  logic [1:0] rsel = 2'h0;
  logic signed [14:0] sample = 15'sh0000;
  logic ready, acq, tbn, flag, strobe, nflag;
  logic [11:0] result, ndata, pdata;
  logic [1:0] cls;
  int fail_count = 0;
  int checks_done = 0;
  // 50 MHz clock
  always #10 sys_clk_i = ~sys_clk_i;
  arrf_core #(.CONV_CYCLES(3), .STRB_CYCLES(2)) arrf_core_i (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .conversion_command_i(cmd), .range_sel_i(rsel), .sample_i(sample),
    .sample_valid_i(svalid), .sample_ready_o(ready), .acquire_o(acq), .result_o(result),
    .top_bit_n_o(tbn), .range_exceeded_flag_o(flag), .result_valid_strobe_o(strobe));
  arrf_latch_model arrf_latch_model_i (.strobe_i(strobe), .result_i(result), .flag_i(flag),
    .new_data_o(ndata), .new_flag_o(nflag), .prev_data_o(pdata), .class_o(cls));
  // compare helpers, one per result width
  task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: flags %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // offer one quantiser word, held until accepted
  task automatic push(input logic signed [14:0] s);
    sample = s;
    svalid = 1'b1;
    for (int n = 0; n < 100 && !ready; n++) @(posedge sys_clk_i) #1;
    chk2({1'b0, ready}, 2'h1);
    @(posedge sys_clk_i) #1;
    svalid = 1'b0;
    // one idle edge so a following push never re-raises valid in the same step
    @(posedge sys_clk_i) #1;
  endtask
  // one conversion, judged through the host latches
  task automatic convert(input logic [11:0] ed, input logic ef);
    cmd = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1 cmd = 1'b0;
    for (int n = 0; n < 100 && !strobe; n++) @(posedge sys_clk_i) #1;
    chk2({1'b0, strobe}, 2'h1);
    chk2({1'b0, acq}, 2'h0);
    chk12(ndata, ed);
    chk2({1'b0, nflag}, {1'b0, ef});
    chk2({1'b0, tbn}, {1'b0, ~ed[11]});
    chk2(cls, !ef ? 2'h0 : (ed[11] ? 2'h2 : 2'h1));
    for (int n = 0; n < 100 && strobe; n++) @(posedge sys_clk_i) #1;
    chk2({1'b0, strobe}, 2'h0);
    chk12(pdata, ed);
    chk2({1'b0, flag}, {1'b0, ef});
  endtask
  task automatic t_ranges();
    for (int r = 0; r < 4; r++) begin
      rsel = r[1:0];
      push(15'sh0000);
      convert(12'h000, 1'b0);
      push(15'sh1FFF);
      convert(12'hFFF, 1'b0);
    end
  endtask
  task automatic t_out_range();
    push(15'sh2008);
    convert(12'hFFF, 1'b1);
    push(-15'sh0004);
    convert(12'h000, 1'b1);
    push(15'sh07D0);
    convert(12'h3E8, 1'b0);
  endtask
  // fill the buffer until refused, then drain in order
  task automatic t_fifo();
    for (int i = 1; i < 5; i++) push(15'(2 * i));
    chk2({1'b0, ready}, 2'h0);
    for (int i = 1; i < 5; i++) convert(12'(i), 1'b0);
  endtask
  // main sequence after a five cycle reset
  initial begin
    repeat (5) @(posedge sys_clk_i);
    #1 resetn_i = 1'b1;
    t_ranges();
    t_out_range();
    t_fifo();
    report_and_stop();
  end
  // watchdog, far beyond the expected run
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
endmodule // adc_result_range_flag_tb
`default_nettype wire
